// [rtl/bgt_tracker.sv]
`timescale 1ns/1ns
// How it works
// - charge raises remaining up to full; drains lower it to zero
// - voltage falling past end or midrange thresholds resets remaining
// - reports remaining in mAh or 10 mWh per the mode bit
// - design capacity comes from the pack capacity word
// - full capacity loads from last measured discharge word at start
// - a new full capacity is written back in mAh within 4 s
// - full capacity is the reference for relative charge
// - hidden discharge counter counts on past remaining reaching zero
// - at zero only measured discharge counts; otherwise estimates too
// - counter loads full minus remaining near full
// - counter stops when the second end threshold hits on discharge
// - new full is counter plus full times battery low percent
// - learning needs a near full start and reaching second threshold
// - ten mAh of charge spoils the learning discharge
// - over 256 mAh of estimated drain spoils it
// - temperature under 5 C spoils it
// - voltage must be above threshold minus 256 mV at detection
// - any midrange correction spoils it
// - one update moves full down at most 256, up at most 512
// - end thresholds are read from configuration memory
// - charge scaled by temperature and fill; self drain by temperature
module bgt_tracker
    import bgt_pkg::*;
#(
    parameter int SAVE_LIMIT = SAVE_LIMIT_CYC  // write-back deadline, cycles
) (
    input  wire logic        mclk,      // 20 MHz clock
    input  wire logic        reset_n,   // sync reset
    input  wire logic        smp_valid, // one sample set this cycle
    input  wire logic [7:0]  smp_chg,   // charge in, mAh
    input  wire logic [7:0]  smp_dsg,   // measured discharge, mAh
    input  wire logic [7:0]  smp_sd,    // self-discharge estimate, mAh
    input  wire logic [7:0]  smp_ld,    // light-discharge estimate, mAh
    input  wire logic [15:0] smp_volt,  // pack voltage, mV
    input  wire logic [15:0] smp_temp,  // temperature, 0.1 K
    input  wire logic [15:0] smp_curr,  // current, mA signed
    input  wire logic [7:0]  reg_addr,  // command code
    input  wire logic        reg_rd,    // read strobe
    input  wire logic        reg_wr,    // write strobe
    input  wire logic [15:0] reg_wdata, // write data
    output logic [15:0]      reg_rdata, // read data
    output logic             reg_ack,   // access done
    output logic             cap_low,   // remaining under alarm level
    output logic [7:0]       ee_addr,   // config memory address
    output logic             ee_rd,     // config read request
    output logic             ee_wr,     // config write request
    output logic [15:0]      ee_wdata,  // config write data
    input  wire logic [15:0] ee_rdata,  // config read data
    input  wire logic        ee_ack     // config request done
);
    if (SAVE_LIMIT < 2) begin : g_chk
        $error("SAVE_LIMIT too small");
    end

    bgt_cfg_if cfg ();

    bgt_cfg_store u_store (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .cfg      (cfg.store),
        .ee_addr  (ee_addr),
        .ee_rd    (ee_rd),
        .ee_wr    (ee_wr),
        .ee_wdata (ee_wdata),
        .ee_rdata (ee_rdata),
        .ee_ack   (ee_ack)
    );

    logic [15:0] rm_q, fcc_q, dcr_q;
    logic [15:0] vend_q, alarm_q, talarm_q, mode_q, rate_q;
    logic [15:0] mean_q, err_q, chg_acc_q, est_acc_q;
    logic [5:0]  below_q;
    logic        loaded_q, dcr_stop_q, armed_q, disq_q;
    logic        save_wait_q;
    logic [31:0] save_age_q;

    ////////////////////////////////////////////////////////////////////
    // compensation
    wire run = smp_valid && loaded_q;
    wire hot = smp_temp > HOT_LIMIT;
    wire [15:0] fill_mark = fcc_q - (fcc_q >> 3);
    wire [7:0] eff = (hot || rm_q >= fill_mark) ? EFF_LOW : EFF_NOM;
    wire [15:0] chg_prod = 16'(smp_chg) * 16'(eff);
    wire [15:0] chg_c = chg_prod >> 7;
    wire [15:0] sd_c = hot ? {7'h00, smp_sd, 1'b0} : {8'h00, smp_sd};
    wire [15:0] est = sd_c + 16'(smp_ld);
    wire [15:0] drain = est + 16'(smp_dsg);

    // raw accounting
    wire signed [17:0] rm_sum = $signed({2'b00, rm_q})
        + $signed({2'b00, chg_c}) - $signed({2'b00, drain});
    wire [15:0] rm_acc = rm_sum < 0 ? 16'h0000
        : rm_sum > $signed({2'b00, fcc_q}) ? fcc_q : rm_sum[15:0];

    ////////////////////////////////////////////////////////////////////
    // voltage thresholds
    wire [23:0] low_prod = 24'(fcc_q) * 24'(cfg.batt_low);
    wire [15:0] low_lvl  = 16'(low_prod / 24'd100);
    wire [15:0] q_lvl    = fcc_q >> 2;
    wire [15:0] h_lvl    = fcc_q >> 1;
    wire [15:0] tq_lvl   = fcc_q - q_lvl;
    wire [5:0]  below = {smp_volt < cfg.midrange_threshold_three_quarter, smp_volt < cfg.midrange_threshold_half,
        smp_volt < cfg.midrange_threshold_quarter, smp_volt < cfg.end_discharge_threshold_2,
        smp_volt < cfg.end_discharge_threshold_1, smp_volt < cfg.end_discharge_threshold_0};
    wire [5:0]  fall = run ? (below & ~below_q) : 6'h00;
    wire [15:0] end_discharge_threshold_1_lvl = low_lvl >> 1;
    wire [15:0] e1_v = rm_acc > end_discharge_threshold_1_lvl ? end_discharge_threshold_1_lvl : rm_acc;
    wire [15:0] e2_v = rm_acc > low_lvl ? low_lvl : rm_acc;
    wire        edv_hit = |fall[2:0];
    wire [15:0] mid_v = fall[3] ? q_lvl : fall[4] ? h_lvl : tq_lvl;
    wire        mid_hit = !edv_hit && |fall[5:3] && mid_v != rm_acc;
    wire [15:0] rm_v = fall[0] ? 16'h0000
        : fall[1] ? e1_v : fall[2] ? e2_v : mid_hit ? mid_v : rm_acc;

    ////////////////////////////////////////////////////////////////////
    // learning
    wire [15:0] nf2 = {7'h00, cfg.near_full, 1'b0};
    wire near = fcc_q <= nf2 || rm_q >= fcc_q - nf2;
    wire load_win = run && near;
    wire [15:0] dcr_inc = rm_q != 16'h0000 ? drain
        : 16'(smp_dsg);
    wire [16:0] dcr_sum = 17'(dcr_q) + 17'(dcr_inc);
    wire [15:0] dcr_nx = dcr_sum[16] ? 16'hFFFF : dcr_sum[15:0];
    wire end_discharge_threshold_2_evt = run && fall[2] && smp_dsg != 8'h00 && !dcr_stop_q;
    wire [16:0] chg_tot = 17'(chg_acc_q) + 17'(smp_chg);
    wire [16:0] est_tot = 17'(est_acc_q) + 17'(est);
    wire spoil = chg_tot >= 17'(VALID_CHG_MAH)
        || est_tot > 17'(EST_LIMIT_MAH)
        || smp_temp < COLD_LIMIT
        || mid_hit;
    wire margin_ok = 17'(smp_volt) + END_DISCHARGE_THRESHOLD_2_MARGIN > 17'(cfg.end_discharge_threshold_2);
    wire qualify = end_discharge_threshold_2_evt && armed_q && !disq_q && !spoil && margin_ok;
    wire [16:0] fcc_raw = 17'(dcr_q) + 17'(low_lvl);
    wire [16:0] fcc_lo = 17'(fcc_q) > FCC_DROP_MAX
        ? 17'(fcc_q) - FCC_DROP_MAX : 17'h00000;
    wire [16:0] fcc_hi = 17'(fcc_q) + FCC_RISE_MAX;
    wire [16:0] fcc_cl = fcc_raw < fcc_lo ? fcc_lo
        : fcc_raw > fcc_hi ? fcc_hi : fcc_raw;
    wire [15:0] fcc_new = fcc_cl[16] ? 16'hFFFF : fcc_cl[15:0];

    assign cfg.save_req  = qualify;
    assign cfg.save_data = fcc_new;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rm_q     <= 16'h0000;
            fcc_q    <= 16'h0000;
            loaded_q <= 1'b0;
            below_q  <= 6'h00;
            err_q    <= ERR_RST;
        end else if (cfg.loaded && !loaded_q) begin
            loaded_q <= 1'b1;
            fcc_q    <= cfg.lmd;
        end else if (qualify) begin
            fcc_q   <= fcc_new;
            rm_q    <= rm_v > fcc_new ? fcc_new : rm_v;
            err_q   <= ERR_LEARNED;
            below_q <= below;
        end else if (run) begin
            rm_q    <= rm_v;
            below_q <= below;
        end
    end

    // the hidden counter reloads every sample while near full
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dcr_q      <= 16'h0000;
            dcr_stop_q <= 1'b0;
            armed_q    <= 1'b0;
            disq_q     <= 1'b0;
            chg_acc_q  <= 16'h0000;
            est_acc_q  <= 16'h0000;
        end else if (load_win) begin
            dcr_q      <= fcc_q - rm_q;
            dcr_stop_q <= 1'b0;
            armed_q    <= 1'b1;
            disq_q     <= 1'b0;
            chg_acc_q  <= 16'h0000;
            est_acc_q  <= 16'h0000;
        end else if (end_discharge_threshold_2_evt) begin
            dcr_stop_q <= 1'b1;
            armed_q    <= 1'b0;
        end else if (run && !dcr_stop_q) begin
            dcr_q     <= dcr_nx;
            disq_q    <= disq_q || spoil;
            chg_acc_q <= chg_tot[16] ? 16'hFFFF : chg_tot[15:0];
            est_acc_q <= est_tot[16] ? 16'hFFFF : est_tot[15:0];
        end
    end

    // age of an outstanding write-back
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            save_wait_q <= 1'b0;
            save_age_q  <= 32'h0000_0000;
        end else if (qualify) begin
            save_wait_q <= 1'b1;
            save_age_q  <= 32'h0000_0000;
        end else if (cfg.save_done) begin
            save_wait_q <= 1'b0;
        end else if (save_wait_q) begin
            save_age_q  <= save_age_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reporting
    wire mwh = mode_q[MODE_CAP_BIT];
    wire [31:0] rm_e  = 32'(rm_q) * 32'(cfg.design_mv);
    wire [31:0] fcc_e = 32'(fcc_q) * 32'(cfg.design_mv);
    wire [31:0] dc_e  = 32'(cfg.pack_cap) * 32'(cfg.design_mv);
    wire [15:0] rm_rep = mwh ? 16'(rm_e / 32'd10000) : rm_q;
    wire [15:0] fcc_rep = mwh ? 16'(fcc_e / 32'd10000) : fcc_q;
    wire [15:0] dc_rep = mwh ? 16'(dc_e / 32'd10000)
        : cfg.pack_cap;
    wire [31:0] rm_pct = 32'(rm_q) * 32'd100;
    wire [15:0] rel = fcc_q == 16'h0000 ? 16'h0000
        : 16'(rm_pct / 32'(fcc_q));
    wire [15:0] abs_v = cfg.pack_cap == 16'h0000 ? 16'h0000
        : 16'(rm_pct / 32'(cfg.pack_cap));
    wire signed [15:0] mean_dif = $signed(smp_curr) - $signed(mean_q);
    assign cap_low = loaded_q && rm_rep < alarm_q;

    logic [15:0] rd_mux;
    always_comb begin
        case (reg_addr)
            CMD_VENDOR:     rd_mux = vend_q;
            CMD_CAP_ALARM:  rd_mux = alarm_q;
            CMD_TIME_ALARM: rd_mux = talarm_q;
            CMD_MODE:       rd_mux = mode_q;
            CMD_AT_RATE:    rd_mux = rate_q;
            CMD_RATE_FULL:  rd_mux = 16'hFFFF;
            CMD_RATE_EMPTY: rd_mux = 16'hFFFF;
            CMD_RATE_OK:    rd_mux = 16'h0001;
            CMD_TEMP:       rd_mux = smp_temp;
            CMD_VOLT:       rd_mux = smp_volt;
            CMD_CURR:       rd_mux = smp_curr;
            CMD_MEAN:       rd_mux = mean_q;
            CMD_ERR:        rd_mux = err_q;
            CMD_REL:        rd_mux = rel;
            CMD_ABS:        rd_mux = abs_v;
            CMD_REM:        rd_mux = rm_rep;
            CMD_FCC:        rd_mux = fcc_rep;
            default:        rd_mux = dc_rep;
        endcase
    end

    wire known = reg_addr <= CMD_FCC;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
            reg_ack   <= 1'b0;
            mean_q    <= 16'h0000;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd) begin
                reg_rdata <= known ? rd_mux : 16'h0000;
            end
            if (smp_valid) begin
                mean_q <= mean_q + 16'(mean_dif >>> 4);
            end
        end
    end

    // writes to read-only codes are acknowledged and dropped
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vend_q   <= RW_RST;
            alarm_q  <= RW_RST;
            talarm_q <= RW_RST;
            mode_q   <= RW_RST;
            rate_q   <= RW_RST;
        end else if (reg_wr) begin
            if (reg_addr == CMD_VENDOR)     vend_q   <= reg_wdata;
            if (reg_addr == CMD_CAP_ALARM)  alarm_q  <= reg_wdata;
            if (reg_addr == CMD_TIME_ALARM) talarm_q <= reg_wdata;
            if (reg_addr == CMD_MODE)       mode_q   <= reg_wdata;
            if (reg_addr == CMD_AT_RATE)    rate_q   <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    rm_zero_start_a: assert property (
        $rose(reset_n) |-> rm_q == 16'h0000)
        else $error("remaining not zero after reset");
    rm_ceiling_a: assert property (rm_q <= fcc_q)
        else $error("remaining above full capacity");
    end_discharge_threshold_0_empty_a: assert property (
        run && fall[0] && !qualify |=> rm_q == 16'h0000)
        else $error("end threshold zero not applied");
    fcc_load_a: assert property (
        cfg.loaded && !loaded_q |=> fcc_q == $past(cfg.lmd))
        else $error("full capacity not loaded");
    save_due_a: assert property (
        save_wait_q |-> save_age_q < 32'(SAVE_LIMIT))
        else $error("write-back late");
    dcr_load_a: assert property (
        load_win |=> dcr_q == $past(fcc_q) - $past(rm_q))
        else $error("counter load wrong");
    dcr_stop_a: assert property (
        dcr_stop_q && !load_win |=> $stable(dcr_q))
        else $error("counter moved while stopped");
    fcc_step_a: assert property (
        qualify |=> 17'(fcc_q) <= 17'($past(fcc_q)) + FCC_RISE_MAX
            && 17'(fcc_q) + FCC_DROP_MAX >= 17'($past(fcc_q)))
        else $error("full capacity step too large");
    cold_spoil_a: assert property (
        run && !load_win && !end_discharge_threshold_2_evt && !dcr_stop_q
            && smp_temp < COLD_LIMIT |=> disq_q)
        else $error("cold discharge not spoiled");
endmodule : bgt_tracker

// [rtl/bgt_pkg.sv]
package bgt_pkg;
    // host command codes
    localparam logic [7:0] CMD_VENDOR     = 8'h00;
    localparam logic [7:0] CMD_CAP_ALARM  = 8'h01;
    localparam logic [7:0] CMD_TIME_ALARM = 8'h02;
    localparam logic [7:0] CMD_MODE       = 8'h03;
    localparam logic [7:0] CMD_AT_RATE    = 8'h04;
    localparam logic [7:0] CMD_RATE_FULL  = 8'h05;
    localparam logic [7:0] CMD_RATE_EMPTY = 8'h06;
    localparam logic [7:0] CMD_RATE_OK    = 8'h07;
    localparam logic [7:0] CMD_TEMP       = 8'h08;
    localparam logic [7:0] CMD_VOLT       = 8'h09;
    localparam logic [7:0] CMD_CURR       = 8'h0A;
    localparam logic [7:0] CMD_MEAN       = 8'h0B;
    localparam logic [7:0] CMD_ERR        = 8'h0C;
    localparam logic [7:0] CMD_REL        = 8'h0D;
    localparam logic [7:0] CMD_ABS        = 8'h0E;
    localparam logic [7:0] CMD_REM        = 8'h0F;
    localparam logic [7:0] CMD_FCC        = 8'h10;
    localparam logic [15:0] RW_RST        = 16'h0000;
    localparam int          MODE_CAP_BIT  = 15;
    // configuration memory word addresses, load order
    localparam int EE_WORDS = 10;
    localparam logic [7:0] EE_LMD = 8'h38;
    localparam logic [7:0] EE_MAP [EE_WORDS] = '{8'h38, 8'h3A, 8'h54,
        8'h72, 8'h74, 8'h76, 8'h78, 8'h7A, 8'h7C, 8'h7E};
    // learning limits, mAh / mV / 0.1 K
    localparam logic [15:0] VALID_CHG_MAH = 16'h000A;
    localparam logic [15:0] EST_LIMIT_MAH = 16'h0100;
    localparam logic [15:0] COLD_LIMIT    = 16'h0ADE;
    localparam logic [15:0] HOT_LIMIT     = 16'h0C6E;
    localparam logic [16:0] END_DISCHARGE_THRESHOLD_2_MARGIN   = 17'h00100;
    localparam logic [16:0] FCC_DROP_MAX  = 17'h00100;
    localparam logic [16:0] FCC_RISE_MAX  = 17'h00200;
    // charge efficiency in 1/128
    localparam logic [7:0]  EFF_NOM       = 8'h7C;
    localparam logic [7:0]  EFF_LOW       = 8'h70;
    localparam logic [15:0] ERR_RST       = 16'h0064;
    localparam logic [15:0] ERR_LEARNED   = 16'h0002;
    localparam int SAVE_LIMIT_S = 4;
    localparam int CLK_HZ       = 20_000_000;
    localparam int SAVE_LIMIT_CYC = SAVE_LIMIT_S * CLK_HZ;
endpackage : bgt_pkg

// [rtl/bgt_cfg_if.sv]
`timescale 1ns/1ns
interface bgt_cfg_if;
    logic [15:0] lmd;
    logic [15:0] pack_cap;
    logic [7:0]  batt_low;
    logic [7:0]  near_full;
    logic [15:0] end_discharge_threshold_0;
    logic [15:0] end_discharge_threshold_1;
    logic [15:0] end_discharge_threshold_2;
    logic [15:0] midrange_threshold_quarter;
    logic [15:0] midrange_threshold_half;
    logic [15:0] midrange_threshold_three_quarter;
    logic [15:0] design_mv;
    logic        loaded;
    logic        save_req;
    logic [15:0] save_data;
    logic        save_done;
    modport store (output lmd, pack_cap, batt_low, near_full, end_discharge_threshold_0,
        end_discharge_threshold_1, end_discharge_threshold_2, midrange_threshold_quarter, midrange_threshold_half, midrange_threshold_three_quarter, design_mv, loaded, save_done,
        input save_req, save_data);
    modport core (input lmd, pack_cap, batt_low, near_full, end_discharge_threshold_0,
        end_discharge_threshold_1, end_discharge_threshold_2, midrange_threshold_quarter, midrange_threshold_half, midrange_threshold_three_quarter, design_mv, loaded, save_done,
        output save_req, save_data);
endinterface : bgt_cfg_if

// [rtl/bgt_cfg_store.sv]
`timescale 1ns/1ns
module bgt_cfg_store
    import bgt_pkg::*;
(
    input  wire logic        mclk,      // system clock
    input  wire logic        reset_n,   // sync reset
    bgt_cfg_if.store         cfg,       // values to the core
    output logic [7:0]       ee_addr,   // memory word address
    output logic             ee_rd,     // read request
    output logic             ee_wr,     // write request
    output logic [15:0]      ee_wdata,  // write data
    input  wire logic [15:0] ee_rdata,  // read data
    input  wire logic        ee_ack     // request done
);
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_RUN  = 3'b010,
        ST_SAVE = 3'b100
    } bgt_st_type;

    bgt_st_type  st_q;
    logic [3:0]  idx_q;
    logic [15:0] word_q [EE_WORDS];
    logic        pend_q;
    wire         last_w = idx_q == 4'(EE_WORDS - 1);

    ////////////////////////////////////////////////////////////////////
    assign ee_rd          = st_q == ST_LOAD;
    assign ee_wr          = st_q == ST_SAVE;
    assign cfg.loaded     = st_q != ST_LOAD;
    assign cfg.save_done  = ee_wr && ee_ack;
    assign cfg.lmd        = word_q[0];
    assign cfg.pack_cap   = word_q[1];
    assign cfg.batt_low   = word_q[2][7:0];
    assign cfg.near_full  = word_q[2][15:8];
    assign cfg.end_discharge_threshold_0       = word_q[3];
    assign cfg.end_discharge_threshold_1       = word_q[4];
    assign cfg.end_discharge_threshold_2       = word_q[5];
    assign cfg.midrange_threshold_quarter      = word_q[6];
    assign cfg.midrange_threshold_half      = word_q[7];
    assign cfg.midrange_threshold_three_quarter      = word_q[8];
    assign cfg.design_mv  = word_q[9];

    always_ff @(posedge mclk) begin
        if (st_q == ST_LOAD && ee_ack) begin
            word_q[idx_q] <= ee_rdata;
        end
    end

    // a request during a save is kept; the newest value wins
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q     <= ST_LOAD;
            idx_q    <= 4'h0;
            pend_q   <= 1'b0;
            ee_addr  <= EE_MAP[0];
            ee_wdata <= 16'h0000;
        end else begin
            if (cfg.save_req) begin
                pend_q   <= 1'b1;
                ee_wdata <= cfg.save_data;
            end
            case (st_q)
                ST_LOAD: begin
                    if (ee_ack && last_w) begin
                        st_q    <= ST_RUN;
                        ee_addr <= EE_LMD;
                    end else if (ee_ack) begin
                        idx_q   <= idx_q + 4'h1;
                        ee_addr <= EE_MAP[idx_q + 4'h1];
                    end
                end
                ST_RUN: begin
                    if (pend_q && !cfg.save_req) begin
                        st_q   <= ST_SAVE;
                        pend_q <= 1'b0;
                    end
                end
                ST_SAVE: begin
                    if (ee_ack) begin
                        st_q <= ST_RUN;
                    end
                end
                default: st_q <= ST_LOAD;
            endcase
        end
    end
endmodule : bgt_cfg_store

// [tb/bgt_ee_model.sv]
`timescale 1ns/1ns
module bgt_ee_model
(
    input  wire logic        mclk,      // system clock
    input  wire logic [7:0]  ee_addr,   // word address
    input  wire logic        ee_rd,     // read request
    input  wire logic        ee_wr,     // write request
    input  wire logic [15:0] ee_wdata,  // write data
    output logic [15:0]      ee_rdata,  // read data
    output logic             ee_ack,    // request done
    output logic [7:0]       wr_addr,   // last written address
    output logic [15:0]      wr_data,   // last written word
    output int               wr_cnt     // writes taken
);
    logic [15:0] mem_q [256];
    logic [15:0] data_q = 16'h0000;
    logic [2:0]  wait_q = 3'h0;
    // alternate words answer slowly so both paths get exercised
    wire logic [2:0] delay = ee_addr[1] ? 3'h3 : 3'h0;
    // released data shows the inverse, never a stale match
    assign ee_rdata = ee_ack ? data_q : ~data_q;
    initial begin
        ee_ack = 1'b0;
        wr_cnt = 0;
        foreach (mem_q[i]) mem_q[i] = 16'h0000;
        mem_q[8'h38] = 16'h03E8;
        mem_q[8'h3A] = 16'h0800;
        mem_q[8'h54] = 16'h320A;
        mem_q[8'h76] = 16'h0BB8;
        mem_q[8'h7E] = 16'h4E20;
    end
    always @(posedge mclk) begin
        ee_ack <= 1'b0;
        if ((ee_rd || ee_wr) && !ee_ack) begin
            if (wait_q == delay) begin
                wait_q <= 3'h0;
                ee_ack <= 1'b1;
                data_q <= mem_q[ee_addr];
                if (ee_wr) begin
                    mem_q[ee_addr] <= ee_wdata;
                    wr_addr <= ee_addr;
                    wr_data <= ee_wdata;
                    wr_cnt <= wr_cnt + 1;
                end
            end else wait_q <= wait_q + 3'h1;
        end else wait_q <= 3'h0;
    end
endmodule : bgt_ee_model

// [tb/tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("wrong value %s exp %h got %h", nm, exp, got); \
    end end
module tb_top
    import bgt_pkg::*;
;
    localparam logic [15:0] VN = 16'h0FA0, VX = 16'h0B54, VL = 16'h0A8C;
    localparam logic [15:0] TN = 16'h0BA4, TC = 16'h0A8C;
    logic        mclk = 1'b0, reset_n = 1'b0, smp_valid = 1'b0;
    logic [7:0]  smp_chg = 8'h00, smp_dsg = 8'h00, smp_sd = 8'h00;
    logic [7:0]  smp_ld = 8'h00, reg_addr = 8'h00, ee_addr;
    logic [15:0] smp_volt = VN, smp_temp = TN, smp_curr = 16'h0000;
    logic        reg_rd = 1'b0, reg_wr = 1'b0, reg_ack, cap_low;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ee_wdata, ee_rdata;
    logic        ee_rd, ee_wr, ee_ack;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
    int          wr_cnt, ee_reads = 0, miscompares = 0, num_checks = 0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) if (reset_n && ee_ack && ee_rd) ee_reads++;
    bgt_tracker #(.SAVE_LIMIT(2000)) dut_u (.mclk, .reset_n, .smp_valid,
        .smp_chg, .smp_dsg, .smp_sd, .smp_ld, .smp_volt, .smp_temp,
        .smp_curr, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
        .reg_ack, .cap_low, .ee_addr, .ee_rd, .ee_wr, .ee_wdata,
        .ee_rdata, .ee_ack);
    bgt_ee_model ee_u (.mclk, .ee_addr, .ee_rd, .ee_wr, .ee_wdata,
        .ee_rdata, .ee_ack, .wr_addr, .wr_data, .wr_cnt);
    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge mclk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_rd = !w;
        reg_wr = w;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        for (n = 0; reg_ack !== 1'b1; n++) begin
            if (n == 4) begin
                miscompares++;
                test_done();
            end
            @(posedge mclk) #1;
        end
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
                      input string nm);
        acc(1'b0, a, 16'h0000);
        `CHK(nm, e, reg_rdata)
    endtask : rd
    task automatic smp(input logic [7:0] c, d, s, l, input logic [15:0] v, t);
        @(posedge mclk) #1;
        {smp_chg, smp_dsg, smp_sd, smp_ld} = {c, d, s, l};
        {smp_volt, smp_temp} = {v, t};
        smp_valid = 1'b1;
        @(posedge mclk) #1;
        smp_valid = 1'b0;
    endtask : smp
    task automatic charge_full(input logic [15:0] f);
        repeat (6) smp(8'hFF, 8'h00, 8'h00, 8'h00, VN, TN);
        rd(CMD_REM, f, "rm full");
    endtask : charge_full
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        acc(1'b1, CMD_CAP_ALARM, 16'h1234);
        rd(CMD_CAP_ALARM, 16'h1234, "alarm rw");
        acc(1'b1, CMD_RATE_FULL, 16'h0001);
        rd(CMD_RATE_FULL, 16'hFFFF, "ro kept");
        rd(8'h20, 16'h0000, "unmapped");
        acc(1'b1, CMD_CAP_ALARM, 16'h0000);
    endtask : t_regs
    task automatic t_learn;
        int n;
        charge_full(16'h03E8);
        rd(CMD_REL, 16'h0064, "relative");
        smp(8'h00, 8'hC8, 8'h00, 8'h00, VN, TN);
        smp(8'h00, 8'h64, 8'h00, 8'h00, VN, TN);
        smp(8'h00, 8'h32, 8'h00, 8'h00, VX, TN);
        rd(CMD_FCC, 16'h02E8, "fcc learned");
        rd(CMD_ERR, ERR_LEARNED, "error bound");
        for (n = 0; wr_cnt < 1; n++) begin
            if (n == 2100) begin
                miscompares++;
                test_done();
            end
            @(posedge mclk) #1;
        end
        `CHK("saved word", 16'h02E8, wr_data)
        `CHK("saved addr", EE_LMD, wr_addr)
    endtask : t_learn
    task automatic t_spoil;
        // one spoiling sample in each of the first four passes; fcc must stay put
        for (int k = 0; k < 5; k++) begin
            charge_full(16'h02E8);
            if (k == 4) begin
                acc(1'b1, CMD_MODE, 16'h8000);
                rd(CMD_REM, 16'h05D0, "rm in mwh");
                acc(1'b1, CMD_MODE, 16'h0000);
                continue;
            end
            smp(8'h00, 8'hC8, 8'h00, 8'h00, VN, TN);
            smp(k == 0 ? 8'h14 : 8'h00, k > 1 ? 8'h32 : 8'h00,
                k == 1 ? 8'hC8 : 8'h00, k == 1 ? 8'h64 : 8'h00,
                VN, k == 2 ? TC : TN);
            smp(8'h00, 8'h32, 8'h00, 8'h00, k == 3 ? VL : VX, TN);
            rd(CMD_FCC, 16'h02E8, "fcc kept");
        end
        `CHK("save count", 1, wr_cnt)
    endtask : t_spoil
    task automatic t_empty;
        repeat (4) smp(8'h00, 8'hFF, 8'h00, 8'h00, VN, TN);
        rd(CMD_REM, 16'h0000, "rm empty");
        acc(1'b1, CMD_CAP_ALARM, 16'h0010);
        `CHK("cap low", 1'b1, cap_low)
    endtask : t_empty
    initial begin
        repeat (4) @(posedge mclk);
        #1 reset_n = 1'b1;
        rd(CMD_REM, 16'h0000, "rm at reset");
        for (int n = 0; ee_reads < 10; n++) begin
            if (n == 300) begin
                miscompares++;
                test_done();
            end
            @(posedge mclk) #1;
        end
        rd(CMD_FCC, 16'h03E8, "fcc loaded");
        t_regs();
        t_learn();
        t_spoil();
        t_empty();
        test_done();
    end
endmodule : tb_top
